// *** q_regs_consts.svh ***
// Offsets, field positions, reset values and scaling figures for the Q channel offset and range registers.
// Assumes a 4-bit register address coming from the control port decoder.
`ifndef Q_REGS_CONSTS_SVH
`define Q_REGS_CONSTS_SVH

`define ADDR_OFFSET_ADJUST 4'ha
`define ADDR_FULL_SCALE_ADJUST 4'hb

`define RESET_OFFSET_ADJUST 16'h0000
`define RESET_FULL_SCALE_ADJUST 16'h4000

`define MASK_OFFSET_ADJUST 16'h1fff
`define MASK_FULL_SCALE_ADJUST 16'h7fff

`define OFFSET_POLARITY_POS 12
`define OFFSET_MAG_MSB 11
`define RANGE_MAG_MSB 14
`define MONOTONIC_BITS 9

`define OFFSET_MAX_UV 32'h0000_afc8
`define OFFSET_MAX_CODE 32'h0000_0fff
`define RANGE_MIN_MV 10'h258
`define RANGE_SPAN_MV 32'h0000_0190
`define RANGE_MAX_CODE 32'h0000_7fff
`define RANGE_NOMINAL_MV 10'h320

`endif

// *** q_regs_pkg.sv ***
// Types shared by the Q channel offset and range register bank.
// Assumes the constants header is included alongside by each design file.
package q_regs_pkg;

	typedef logic [15:0] word_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'h1,
		SEL_OFFSET = 3'h2,
		SEL_RANGE = 3'h4
	} reg_sel_e;

endpackage

// *** config_word.sv ***
// One 16-bit control word with a reset value and a mask of writable bits.
// Assumes write strobes from logic on the same clock; masked-out bits always hold zero.
`timescale 1ns/1ps

module config_word #(
	parameter logic [15:0] RESET_VALUE = 16'h0000,
	parameter logic [15:0] WRITE_MASK = 16'hffff
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] word_q
);

	logic [15:0] word_reg;
	logic [15:0] word_next;

	// Reserved positions are forced to zero so readback never shows host mistakes
	assign word_next = wr_en ? (wr_data & WRITE_MASK) : word_reg;

	// Word holds until the next write or reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			word_reg <= RESET_VALUE;
		end else begin
			word_reg <= word_next;
		end
	end

	assign word_q = word_reg;

endmodule

// *** q_channel_offset_range_regs.sv ***
// Q channel offset and full-scale range control registers with decoded field outputs.
// Assumes the serial control port deframer on clk presents parallel word reads and writes.
//
// Operation
// - Offset bit 12 selects polarity: 0 positive (reset), 1 negative of the same magnitude.
// - Offset bits 11:0 are an unsigned magnitude from 0 at code 0 to 45 mV at code 4095.
// - The offset magnitude resets to zero and the midpoint code gives half the maximum offset.
// - Only the nine most significant bits of each magnitude field are monotonic.
// - Range bits 14:0 map linearly from 600 mV at code 0 to 1000 mV at code 32767.
// - The range field resets to code 16384, an 800 mV full scale, register value with bit 14 set.
// - With extended control mode the range field is used; without it the span stays at 800 mV.
`timescale 1ns/1ps
`include "q_regs_consts.svh"

module q_channel_offset_range_regs (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic extended_control_mode,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic offset_polarity_bit,
	output logic [11:0] offset_magnitude_field,
	output logic [14:0] range_magnitude_field,
	output logic [8:0] offset_monotonic_code,
	output logic [8:0] range_monotonic_code,
	output logic [16:0] offset_uv,
	output logic [9:0] full_scale_span
);

	localparam logic [15:0] RESET_WORDS [2] = '{`RESET_OFFSET_ADJUST, `RESET_FULL_SCALE_ADJUST};
	localparam logic [15:0] MASK_WORDS [2] = '{`MASK_OFFSET_ADJUST, `MASK_FULL_SCALE_ADJUST};

	q_regs_pkg::reg_sel_e sel;
	logic [1:0] word_wr;
	q_regs_pkg::word_t words [2];
	q_regs_pkg::word_t rd_word;
	logic [11:0] off_mag;
	logic [14:0] rng_mag;
	logic off_neg;
	logic [31:0] off_product;
	logic [31:0] off_uv_abs;
	logic [16:0] off_uv_signed;
	logic [31:0] rng_product;
	logic [31:0] rng_add_mv;
	logic [9:0] span_sel;

	logic [15:0] rd_data_reg;
	logic rd_valid_reg;
	logic polarity_reg;
	logic [11:0] off_mag_reg;
	logic [14:0] rng_mag_reg;
	logic [8:0] off_mono_reg;
	logic [8:0] rng_mono_reg;
	logic [16:0] offset_uv_reg;
	logic [9:0] span_reg;

	// Address decode; anything else selects nothing and reads zero
	assign sel = (addr == `ADDR_OFFSET_ADJUST) ? q_regs_pkg::SEL_OFFSET :
		(addr == `ADDR_FULL_SCALE_ADJUST) ? q_regs_pkg::SEL_RANGE : q_regs_pkg::SEL_NONE;
	assign word_wr[0] = wr_en && (sel == q_regs_pkg::SEL_OFFSET);
	assign word_wr[1] = wr_en && (sel == q_regs_pkg::SEL_RANGE);

	// One storage word per register; reserved bits are masked so a careless host cannot set them
	generate
		for (genvar i = 0; i < 2; i++) begin : g_word
			config_word #(
				.RESET_VALUE(RESET_WORDS[i]),
				.WRITE_MASK(MASK_WORDS[i])
			) u_word (
				.clk(clk),
				.nrst(nrst),
				.wr_en(word_wr[i]),
				.wr_data(wr_data),
				.word_q(words[i])
			);
		end
	endgenerate

	// Readback mux; a read in the write cycle returns the old value
	assign rd_word = (sel == q_regs_pkg::SEL_OFFSET) ? words[0] :
		(sel == q_regs_pkg::SEL_RANGE) ? words[1] : 16'h0000;

	// Field extraction
	assign off_neg = words[0][`OFFSET_POLARITY_POS];
	assign off_mag = words[0][`OFFSET_MAG_MSB:0];
	assign rng_mag = words[1][`RANGE_MAG_MSB:0];

	// Offset in microvolts: code * 45000 / 4095, so 4095 lands exactly on 45 mV
	assign off_product = {20'h0_0000, off_mag} * `OFFSET_MAX_UV;
	assign off_uv_abs = off_product / `OFFSET_MAX_CODE;
	assign off_uv_signed = off_neg ? 17'(~off_uv_abs[16:0] + 17'h0_0001) : off_uv_abs[16:0];

	// Range in millivolts: 600 + code * 400 / 32767, code 16384 gives 800
	assign rng_product = {17'h0_0000, rng_mag} * `RANGE_SPAN_MV;
	assign rng_add_mv = rng_product / `RANGE_MAX_CODE;
	// Without extended mode the span stays nominal; values above 800 mV need the extended mode
	assign span_sel = extended_control_mode ? 10'(`RANGE_MIN_MV + rng_add_mv[9:0]) : `RANGE_NOMINAL_MV;

	// Next values of the output flops; kept as wires so every flop below is a plain load
	// Field outputs are registered so downstream analog trims see clean levels
	logic [15:0] rd_data_next;
	logic rd_valid_next;
	logic polarity_next;
	logic [11:0] off_mag_next;
	logic [14:0] rng_mag_next;
	logic [8:0] off_mono_next;
	logic [8:0] rng_mono_next;
	logic [16:0] offset_uv_next;
	logic [9:0] span_next;

	// Read port; rd_data holds between reads, rd_valid pulses one cycle after the request
	assign rd_data_next = rd_en ? rd_word : rd_data_reg;
	assign rd_valid_next = rd_en;

	// Field copies follow the stored words by one clock
	assign polarity_next = off_neg;
	assign off_mag_next = off_mag;
	assign rng_mag_next = rng_mag;

	// Monotonic portions only; low bits are trim and may step non-monotonically
	assign off_mono_next = off_mag[`OFFSET_MAG_MSB -: `MONOTONIC_BITS];
	assign rng_mono_next = rng_mag[`RANGE_MAG_MSB -: `MONOTONIC_BITS];

	// Scaled values take the same one-clock lag as the fields they are made from
	assign offset_uv_next = off_uv_signed;
	assign span_next = span_sel;

	// Read data; cleared by reset so an early read sees zeros rather than power-up noise
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_data_reg <= 16'h0000;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end

	// Read answer, a single-cycle pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= rd_valid_next;
		end
	end

	// Offset sign; reset gives a positive offset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			polarity_reg <= 1'b0;
		end else begin
			polarity_reg <= polarity_next;
		end
	end

	// Offset magnitude; reset applies no offset until the host programs one
	always_ff @(posedge clk) begin
		if (!nrst) begin
			off_mag_reg <= 12'h000;
		end else begin
			off_mag_reg <= off_mag_next;
		end
	end

	// Range magnitude; reset is the mid code so the span starts nominal
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rng_mag_reg <= 15'h4000;
		end else begin
			rng_mag_reg <= rng_mag_next;
		end
	end

	// Monotonic offset code; reset matches the zero magnitude
	always_ff @(posedge clk) begin
		if (!nrst) begin
			off_mono_reg <= 9'h000;
		end else begin
			off_mono_reg <= off_mono_next;
		end
	end

	// Monotonic range code; reset is the top bits of the mid code
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rng_mono_reg <= 9'h100;
		end else begin
			rng_mono_reg <= rng_mono_next;
		end
	end

	// Signed offset in microvolts; reset matches the zero offset word
	always_ff @(posedge clk) begin
		if (!nrst) begin
			offset_uv_reg <= 17'h0_0000;
		end else begin
			offset_uv_reg <= offset_uv_next;
		end
	end

	// Span in millivolts; reset is nominal whatever the mode input says, as the mid code gives the same
	always_ff @(posedge clk) begin
		if (!nrst) begin
			span_reg <= `RANGE_NOMINAL_MV;
		end else begin
			span_reg <= span_next;
		end
	end

	// Every output comes straight from its flop
	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign offset_polarity_bit = polarity_reg;
	assign offset_magnitude_field = off_mag_reg;
	assign range_magnitude_field = rng_mag_reg;
	assign offset_monotonic_code = off_mono_reg;
	assign range_monotonic_code = rng_mono_reg;
	assign offset_uv = offset_uv_reg;
	assign full_scale_span = span_reg;

endmodule

// *** q_regs_checker.sv ***
// Port assertions for the Q channel offset and range register bank.
// Assumes a bind onto the top module; field outputs lag the stored words by one clock.
`timescale 1ns/1ps
module q_regs_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic extended_control_mode,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic offset_polarity_bit,
	input wire logic [11:0] offset_magnitude_field,
	input wire logic [14:0] range_magnitude_field,
	input wire logic [8:0] offset_monotonic_code,
	input wire logic [8:0] range_monotonic_code,
	input wire logic [16:0] offset_uv,
	input wire logic [9:0] full_scale_span
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Scaled values are worked out here with floor division
	wire [31:0] uv = offset_magnitude_field * 32'h0000_afc8 / 32'h0000_0fff;
	wire [31:0] sp = 32'h0000_0258 + range_magnitude_field * 32'h0000_0190 / 32'h0000_7fff;
	wire wa = wr_en && addr == 4'ha;
	wire wb = wr_en && addr == 4'hb;
	pol_track_a: assert property (wa |-> ##2 offset_polarity_bit == $past(wr_data[12], 2)) else $error("pol");
	mag_track_a: assert property (wa |-> ##2 offset_magnitude_field == $past(wr_data[11:0], 2))
		else $error("mag");
	range_track_a: assert property (wb |-> ##2 range_magnitude_field == $past(wr_data[14:0], 2))
		else $error("rng");
	read_pulse_a: assert property (rd_en |=> rd_valid) else $error("read answer missing");
	read_idle_a: assert property (!rd_en |=> !rd_valid) else $error("stray read answer");
	reset_fields_a: assert property ($rose(nrst) |-> !offset_magnitude_field && range_magnitude_field == 15'h4000)
		else $error("rst");
	mono_codes_a: assert property (offset_monotonic_code == offset_magnitude_field[11:3]
		&& range_monotonic_code == range_magnitude_field[14:6]) else $error("mono");
	span_mode_a: assert property (full_scale_span == ($past(extended_control_mode) ? sp[9:0] : 10'h320))
		else $error("span");
	uv_scale_a: assert property (offset_uv == (offset_polarity_bit ? -uv[16:0] : uv[16:0])) else $error("uv");
	range_hold_a: assert property (rd_en && addr == 4'hb && !$past(wr_en)
		|=> rd_data == {1'b0, $past(range_magnitude_field)}) else $error("hold");
	cover property (wa ##2 offset_polarity_bit);
	cover property (rd_en && addr == 4'hb);
	cover property (extended_control_mode && range_magnitude_field == 15'h7fff);
endmodule

// *** host_model.sv ***
// Host side model issuing whole-word register writes and reads.
// Assumes read data is valid one edge after the read is taken.
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic [15:0] rd_data,
	output logic wr_en = 1'b0,
	output logic rd_en = 1'b0,
	output logic [3:0] addr = 4'h0,
	output logic [15:0] wr_data = 16'h0000
);
	// Reserved positions leave the host as zero; data is scrambled after use
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d & (a == 4'ha ? 16'h1fff : 16'h7fff);
		@(posedge clk);
		wr_en <= 1'b0;
		wr_data <= ~d;
	endtask
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		d = rd_data;
	endtask
endmodule

// *** q_channel_offset_range_regs_bench.sv ***
// Self-checking bench for the Q channel offset and range registers.
// Assumes the host model and checker files compile first.
`timescale 1ns/1ps
module q_channel_offset_range_regs_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic extended_control_mode = 1'b0;
	logic wr_en, rd_en;
	logic [3:0] addr;
	logic [15:0] wr_data, rd_data, v, d;
	logic [16:0] offset_uv;
	logic [9:0] full_scale_span;
	logic [15:0] corner[4] = '{16'h0000, 16'hffff, 16'h1800, 16'h4000};
	integer seed = 20, errors = 0, compares = 0, i;
	initial begin
		forever #25 clk = ~clk;
	end
	host_model i_host_model (.clk, .rd_data, .wr_en, .rd_en, .addr, .wr_data);
	q_channel_offset_range_regs i_q_channel_offset_range_regs (.clk, .nrst, .wr_en, .rd_en, .addr, .wr_data,
		.extended_control_mode, .rd_data, .rd_valid(), .offset_polarity_bit(), .offset_magnitude_field(),
		.range_magnitude_field(), .offset_monotonic_code(), .range_monotonic_code(), .offset_uv, .full_scale_span);
	// Signed offset in microvolts, floor of the scaled magnitude
	function automatic logic [16:0] uv_of(input logic [15:0] w);
		logic [16:0] m;
		m = 17'(32'(w[11:0]) * 32'h0000_afc8 / 32'h0000_0fff);
		return w[12] ? -m : m;
	endfunction
	// Span in millivolts: nominal without the extended mode, else 600 plus the floor of the scaled code
	function automatic logic [9:0] span_of(input logic [15:0] w, input logic mode);
		logic [31:0] a;
		a = 32'(w[14:0]) * 32'h0000_0190 / 32'h0000_7fff;
		return mode ? 10'(32'h0000_0258 + a) : 10'h320;
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Corner words first, then random ones, with the mode toggling
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		i_host_model.rd(4'ha, d);
		chk("offset reset", d, 16'h0000);
		i_host_model.rd(4'hb, d);
		chk("range reset", d, 16'h4000);
		$display("reset test done");
		for (i = 0; i < 24; i++) begin
			v = i < 4 ? corner[i] : 16'($random(seed));
			extended_control_mode <= i[0];
			i_host_model.wr(4'ha, v);
			i_host_model.wr(4'hb, v);
			i_host_model.rd(4'ha, d);
			chk("offset word", d, v & 16'h1fff);
			chk("offset uv", offset_uv, uv_of(v));
			i_host_model.rd(4'hb, d);
			chk("range word", d, v & 16'h7fff);
			chk("span", full_scale_span, span_of(v, i[0]));
		end
		$display("word test done");
		i_host_model.wr(4'h3, 16'h1234);
		i_host_model.rd(4'ha, d);
		chk("unmapped write", d, v & 16'h1fff);
		i_host_model.rd(4'h3, d);
		chk("unmapped", d, 16'h0000);
		$display("unmapped test done");
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		i_host_model.rd(4'ha, d);
		chk("offset after reset", d, 16'h0000);
		i_host_model.rd(4'hb, d);
		chk("range after reset", d, 16'h4000);
		chk("span after reset", full_scale_span, span_of(16'h4000, extended_control_mode));
		$display("second reset test done");
		end_of_test;
	end
	// Run needs about 270 cycles; this cuts off a hang
	initial begin
		#100000;
		errors++;
		end_of_test;
	end
endmodule
bind q_channel_offset_range_regs q_regs_checker i_q_regs_checker (.clk, .nrst, .wr_en, .rd_en, .addr, .wr_data,
	.extended_control_mode, .rd_data, .rd_valid, .offset_polarity_bit, .offset_magnitude_field, .range_magnitude_field,
	.offset_monotonic_code, .range_monotonic_code, .offset_uv, .full_scale_span);
